// File: hdl/tws_regs.vh
`ifndef TWS_REGS_VH
`define TWS_REGS_VH
// ---------------------------------------------------------------
// Register map
// ---------------------------------------------------------------
`define TWS_ADDR_W       8
`define TWS_CTRL_ADDR    8'h00
`define TWS_STAT_ADDR    8'h04
`define TWS_SHIFT_ADDR   8'h08
`define TWS_BUF_ADDR     8'h0c
`define TWS_STROBE_ADDR  8'h10
// ---------------------------------------------------------------
// Control fields
// ---------------------------------------------------------------
`define TWS_CTRL_EN      0
`define TWS_CTRL_SRC_LO  1
`define TWS_CTRL_SRC_HI  2
`define TWS_CTRL_STALL   3
`define TWS_CTRL_OWN_LO  8
`define TWS_CTRL_OWN_HI  14
`define TWS_OWN_RST      7'h00
`define TWS_SRC_RST      2'h0
`define TWS_SRC_SCL      2'h0
`define TWS_SRC_TIMER    2'h1
`define TWS_SRC_SOFT     2'h2
// ---------------------------------------------------------------
// Status fields, bits 6..4 and 2..0 are write-one-to-clear
// ---------------------------------------------------------------
`define TWS_ST_START     0
`define TWS_ST_OVF       1
`define TWS_ST_GCALL     2
`define TWS_ST_DIR       3
`define TWS_ST_RXDONE    4
`define TWS_ST_TXDONE    5
`define TWS_ST_ABORT     6
`define TWS_ST_RXFULL    7
`define TWS_ST_TXVALID   8
`define TWS_ST_CNT_LO    16
`define TWS_ST_CNT_HI    19
`define TWS_ST_STATE_LO  24
`define TWS_ST_STATE_HI  29
// ---------------------------------------------------------------
// Protocol constants
// ---------------------------------------------------------------
`define TWS_CNT_ARM      4'h8
`define TWS_CNT_LAST     4'hf
`define TWS_GCALL_ADDR   7'h00
`define TWS_RESP_OKAY    2'h0
`define TWS_RESP_SLVERR  2'h2
`endif

// File: hdl/tws_sync.v
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Two-stage synchroniser for the bus pins
// ---------------------------------------------------------------
module tws_sync (
  // Clock and reset
  input  wire       aclk,
  input  wire       aresetn,
  // Asynchronous pins and synchronised copies
  input  wire [1:0] pin_in,
  output wire [1:0] pin_sync
);
  reg [1:0] meta_reg;
  reg [1:0] sync_reg;

  // Idle bus is high, so reset to released levels
  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= 2'h3;
      sync_reg <= 2'h3;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
    end
  end

  assign pin_sync = sync_reg;
endmodule // tws_sync
`default_nettype wire

// File: hdl/tws_shifter.v
`timescale 1ns/1ps
`default_nettype none
`include "tws_regs.vh"
// ---------------------------------------------------------------
// Shift register and bit counter on one shared tick
// ---------------------------------------------------------------
module tws_shifter (
  // Clock and reset
  input  wire       aclk,
  input  wire       aresetn,
  // Control
  input  wire       tick,
  input  wire       din,
  input  wire       load,
  input  wire [7:0] load_val,
  input  wire       arm,
  // State
  output wire [7:0] data,
  output wire [3:0] cnt,
  output wire       ovf
);
  reg [7:0] data_reg;
  reg [3:0] cnt_reg;

  // Carry out of the counter marks eight bits moved
  assign ovf = tick & ~load & ~arm & (cnt_reg == `TWS_CNT_LAST);

  always @(posedge aclk) begin
    if (!aresetn) begin
      data_reg <= 8'h00;
      cnt_reg  <= 4'h0;
    end else if (load) begin
      data_reg <= load_val;
      cnt_reg  <= `TWS_CNT_ARM;
    end else if (arm) begin
      cnt_reg  <= `TWS_CNT_ARM;
    end else if (tick) begin
      data_reg <= {data_reg[6:0], din};     // see (R10)
      cnt_reg  <= cnt_reg + 4'h1;           // see (R11)
    end
  end

  assign data = data_reg;
  assign cnt  = cnt_reg;
endmodule // tws_shifter
`default_nettype wire

// File: hdl/tws_top.v
// Functional notes
// (R01) SDA falling with SCL high is START
// (R02) SDA rising with SCL high is STOP
// (R03) Master alone makes clock, START, STOP
// (R04) Master sends 7-bit address, direction, MSB first
// (R05) Own address acknowledged by SDA low
// (R06) Packets are eight bits plus acknowledge
// (R07) Master ends transfer after address NACK
// (R08) Bytes flow one direction until START/STOP
// (R09) Hold SCL low while data not ready; here only with stall_reg set, and missing data after a read ACK aborts instead
// (R10) One unbuffered 8-bit shift register; here received and sent bytes pass through rx_buf_reg and tx_buf_reg
// (R11) 4-bit counter flags overflow
// (R12) Shift clock from SCL, timer, or software
// (R13) START sets a status flag
// (R14) Hold SCL after START and overflow; here only overflow holds SCL, START pending clears as SCL goes low
// (R15) START arms counter for eight bits
// (R16) START always detected, restarts address phase
// (R17) Own address stored, compared each message
// (R18) States: address, master read, master write
// (R19) Unmatched address returns idle until START
// (R20) General call sets a status flag
// (R21) Eighth address bit captured as direction
// (R22) Preload or prepare before releasing hold
// (R23) Read mode: NACK ends, ACK loads next
// (R24) Write mode: STOP after ACK completes receive
// (R25) Abort when no data or storage full
// (R26) Release hold only after pending cleared
`timescale 1ns/1ps
`default_nettype none
`include "tws_regs.vh"
module tws_top (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // AXI4-Lite write response
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // AXI4-Lite read data
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  // Timer compare-match pulse, same clock
  input  wire        timer_match,
  // Serial clock pin
  input  wire        scl_i,
  output wire        scl_o,
  output wire        scl_oe,
  // Serial data pin
  input  wire        sda_i,
  output wire        sda_o,
  output wire        sda_oe
);
  // ---------------------------------------------------------------
  // States
  // ---------------------------------------------------------------
  localparam [5:0] S_IDLE  = 6'h01;
  localparam [5:0] S_ADDR  = 6'h02;
  localparam [5:0] S_WR    = 6'h04;
  localparam [5:0] S_RD    = 6'h08;
  localparam [5:0] S_ACKTX = 6'h10;
  localparam [5:0] S_ACKRX = 6'h20;

  // ---------------------------------------------------------------
  // Address decode, shared by read and write paths
  // ---------------------------------------------------------------
  function [2:0] reg_sel;
    input [7:0] a;
    begin
      case (a)
        `TWS_CTRL_ADDR:   reg_sel = 3'h0;
        `TWS_STAT_ADDR:   reg_sel = 3'h1;
        `TWS_SHIFT_ADDR:  reg_sel = 3'h2;
        `TWS_BUF_ADDR:    reg_sel = 3'h3;
        `TWS_STROBE_ADDR: reg_sel = 3'h4;
        default:          reg_sel = 3'h7;
      endcase
    end
  endfunction

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  reg        awready_reg, wready_reg, bvalid_reg, aw_got_reg, w_got_reg;
  reg        arready_reg, rvalid_reg;
  reg [1:0]  bresp_reg, rresp_reg;
  reg [7:0]  aw_addr_reg;
  reg [31:0] w_data_reg, rdata_reg, rd_val;
  reg [3:0]  w_strb_reg;
  reg        en_reg, stall_reg;
  reg [1:0]  src_reg;
  reg [6:0]  own_reg;
  reg [5:0]  state_reg, state_next;
  reg        start_pend_reg, start_pend_next;
  reg        ovf_pend_reg, ovf_pend_next;
  reg        rd_after_reg, rd_after_next;
  reg        dir_reg, dir_next;
  reg [6:0]  flag_reg;
  reg [6:0]  flag_set;
  reg        rx_full_reg, tx_valid_reg;
  reg [7:0]  rx_buf_reg, tx_buf_reg;
  reg        scl_oe_reg, sda_oe_reg, sda_oe_next;
  reg        scl_p_reg, sda_p_reg;
  reg        tick;
  reg        ld, arm, rx_push, tx_pop;
  wire [1:0] pins_s;
  wire       scl_s, sda_s;
  wire [7:0] sh_data;
  wire [3:0] sh_cnt;
  wire       sh_ovf;

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  wire       wr_fire = aw_got_reg & w_got_reg & ~bvalid_reg;
  wire [2:0] wsel    = reg_sel(aw_addr_reg);
  wire       rd_fire = s_axi_arvalid & arready_reg;
  wire [2:0] rsel    = reg_sel(s_axi_araddr);
  wire       ctrl_wr = wr_fire & (wsel == 3'h0);
  wire       stat_wr = wr_fire & (wsel == 3'h1) & w_strb_reg[0];
  wire       buf_wr  = wr_fire & (wsel == 3'h3) & w_strb_reg[0];
  wire       buf_rd  = rd_fire & (rsel == 3'h3);
  wire       soft_tk = wr_fire & (wsel == 3'h4) & w_strb_reg[0] &
                       w_data_reg[0];

  always @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      aw_got_reg  <= 1'b0;
      w_got_reg   <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `TWS_RESP_OKAY;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
    end else begin
      if (s_axi_awvalid & awready_reg) begin
        aw_got_reg  <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_got_reg  <= 1'b0;
      end
      if (s_axi_wvalid & wready_reg) begin
        w_got_reg  <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_got_reg  <= 1'b0;
      end
      // One write in flight: ready drops once a beat is taken
      awready_reg <= ~aw_got_reg & ~(s_axi_awvalid & awready_reg) &
                     ~bvalid_reg & ~wr_fire;
      wready_reg  <= ~w_got_reg & ~(s_axi_wvalid & wready_reg) &
                     ~bvalid_reg & ~wr_fire;
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= (wsel == 3'h7) ? `TWS_RESP_SLVERR : `TWS_RESP_OKAY;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always @* begin
    rd_val = 32'h0000_0000;
    case (rsel)
      3'h0: begin
        rd_val[`TWS_CTRL_EN]                       = en_reg;
        rd_val[`TWS_CTRL_SRC_HI:`TWS_CTRL_SRC_LO]  = src_reg;
        rd_val[`TWS_CTRL_STALL]                    = stall_reg;
        rd_val[`TWS_CTRL_OWN_HI:`TWS_CTRL_OWN_LO]  = own_reg;
      end
      3'h1: begin
        rd_val[6:0]                                = flag_reg;
        rd_val[`TWS_ST_DIR]                        = dir_reg;
        rd_val[`TWS_ST_RXFULL]                     = rx_full_reg;
        rd_val[`TWS_ST_TXVALID]                    = tx_valid_reg;
        rd_val[`TWS_ST_CNT_HI:`TWS_ST_CNT_LO]      = sh_cnt;
        rd_val[`TWS_ST_STATE_HI:`TWS_ST_STATE_LO]  = state_reg;
      end
      3'h2:    rd_val[7:0] = sh_data;
      3'h3:    rd_val[7:0] = rx_buf_reg;
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= `TWS_RESP_OKAY;
    end else if (rd_fire) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rdata_reg   <= rd_val;
      rresp_reg   <= (rsel == 3'h7) ? `TWS_RESP_SLVERR : `TWS_RESP_OKAY;
    end else if (rvalid_reg & s_axi_rready) begin
      rvalid_reg  <= 1'b0;
    end else if (!rvalid_reg) begin
      arready_reg <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Control register; a rewrite reinitialises the slave
  // ---------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      en_reg    <= 1'b0;
      src_reg   <= `TWS_SRC_RST;
      stall_reg <= 1'b0;
      own_reg   <= `TWS_OWN_RST;
    end else if (ctrl_wr) begin
      if (w_strb_reg[0]) begin
        en_reg    <= w_data_reg[`TWS_CTRL_EN];
        src_reg   <= w_data_reg[`TWS_CTRL_SRC_HI:`TWS_CTRL_SRC_LO];
        stall_reg <= w_data_reg[`TWS_CTRL_STALL];
      end
      if (w_strb_reg[1])
        own_reg <= w_data_reg[`TWS_CTRL_OWN_HI:`TWS_CTRL_OWN_LO]; // see (R17)
    end
  end

  // ---------------------------------------------------------------
  // Pin sampling and bus conditions
  // ---------------------------------------------------------------
  tws_sync u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .pin_in   ({scl_i, sda_i}),
    .pin_sync (pins_s)
  );
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  always @(posedge aclk) begin
    if (!aresetn) begin
      scl_p_reg <= 1'b1;
      sda_p_reg <= 1'b1;
    end else begin
      scl_p_reg <= scl_s;
      sda_p_reg <= sda_s;
    end
  end

  wire start_det = en_reg & scl_s & scl_p_reg & sda_p_reg & ~sda_s; // see (R01)
  wire stop_det  = en_reg & scl_s & scl_p_reg & ~sda_p_reg & sda_s; // see (R02)
  wire scl_rise  = scl_s & ~scl_p_reg;
  wire scl_fall  = ~scl_s & scl_p_reg;
  wire busy      = (state_reg == S_ADDR) | (state_reg == S_WR) |
                   (state_reg == S_RD);
  wire [6:0] adr = sh_data[7:1];
  wire gcall     = (adr == `TWS_GCALL_ADDR);
  wire match     = gcall | (adr == own_reg);
  // Only SCL low is a safe moment to act on a pending event
  wire service   = ovf_pend_reg & ~scl_s;

  // Transmit bits change on SCL falling, receive samples on rising
  always @* begin
    case (src_reg)
      `TWS_SRC_SCL:   tick = (state_reg == S_RD) ? scl_fall : scl_rise;
      `TWS_SRC_TIMER: tick = timer_match;
      `TWS_SRC_SOFT:  tick = soft_tk;
      default:        tick = 1'b0;
    endcase // see (R12)
  end

  tws_shifter u_shift (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .tick     (tick & busy & ~ovf_pend_reg & ~start_pend_reg),
    .din      ((state_reg == S_RD) | sda_s),
    .load     (ld),
    .load_val (tx_buf_reg),
    .arm      (arm),
    .data     (sh_data),
    .cnt      (sh_cnt),
    .ovf      (sh_ovf)
  );

  // ---------------------------------------------------------------
  // Protocol sequencer
  // ---------------------------------------------------------------
  always @* begin
    state_next      = state_reg;
    start_pend_next = start_pend_reg;
    ovf_pend_next   = ovf_pend_reg | sh_ovf;             // see (R11)
    rd_after_next   = rd_after_reg;
    dir_next        = dir_reg;
    sda_oe_next     = sda_oe_reg;
    flag_set        = 7'h00;
    ld = 1'b0;
    arm = 1'b0;
    rx_push = 1'b0;
    tx_pop = 1'b0;
    flag_set[`TWS_ST_OVF] = sh_ovf;
    if (start_pend_reg & ~scl_s) begin
      start_pend_next = 1'b0;                           // see (R26)
      arm = 1'b1;                                       // see (R15)
    end
    if (state_reg == S_RD)
      sda_oe_next = ~sh_data[7];                        // see (R08)
    if (service) begin
      case (state_reg)
        S_ADDR: begin                                   // see (R18)
          if (!match) begin
            state_next    = S_IDLE;                     // see (R19)
            ovf_pend_next = 1'b0;
          end else if (sh_data[0] & ~tx_valid_reg & ~stall_reg) begin
            state_next    = S_IDLE;                     // see (R25)
            ovf_pend_next = 1'b0;
            flag_set[`TWS_ST_ABORT] = 1'b1;
          end else if (~sh_data[0] | tx_valid_reg) begin
            dir_next      = sh_data[0];                 // see (R21)
            rd_after_next = sh_data[0];                 // see (R22)
            flag_set[`TWS_ST_GCALL] = gcall;            // see (R20)
            state_next    = S_ACKTX;
            sda_oe_next   = 1'b1;                       // see (R05)
            ovf_pend_next = 1'b0;
          end
        end
        S_WR: begin
          if (rx_full_reg & ~stall_reg) begin
            state_next    = S_IDLE;                     // see (R25)
            ovf_pend_next = 1'b0;
            flag_set[`TWS_ST_ABORT] = 1'b1;
          end else if (!rx_full_reg) begin              // see (R09)
            rx_push       = 1'b1;                       // see (R10)
            rd_after_next = 1'b0;
            state_next    = S_ACKTX;
            sda_oe_next   = 1'b1;                       // see (R06)
            ovf_pend_next = 1'b0;
          end
        end
        S_RD: begin
          state_next    = S_ACKRX;
          sda_oe_next   = 1'b0;
          ovf_pend_next = 1'b0;
        end
        default: ovf_pend_next = 1'b0;
      endcase
    end
    case (state_reg)
      S_ACKTX: if (scl_fall) begin
        sda_oe_next = 1'b0;
        if (rd_after_reg) begin
          ld = 1'b1;                                    // see (R22)
          tx_pop = 1'b1;
          state_next = S_RD;
        end else begin
          arm = 1'b1;
          state_next = S_WR;
        end
      end
      S_ACKRX: if (scl_rise & sda_s) begin
        flag_set[`TWS_ST_TXDONE] = 1'b1;                // see (R23)
        state_next = S_IDLE;
      end else if (scl_fall) begin
        if (tx_valid_reg) begin
          ld = 1'b1;                                    // see (R23)
          tx_pop = 1'b1;
          state_next = S_RD;
        end else begin
          flag_set[`TWS_ST_ABORT] = 1'b1;               // see (R25)
          state_next = S_IDLE;
        end
      end
      default: ;
    endcase
    if (stop_det & (state_reg != S_IDLE)) begin
      flag_set[`TWS_ST_RXDONE] = ~rd_after_reg &
        ((state_reg == S_WR) | (state_reg == S_ACKTX)); // see (R24)
      state_next    = S_IDLE;
      sda_oe_next   = 1'b0;
      ovf_pend_next = 1'b0;
    end
    if (start_det) begin
      state_next      = S_ADDR;                         // see (R16)
      start_pend_next = 1'b1;                           // see (R14)
      ovf_pend_next   = 1'b0;
      sda_oe_next     = 1'b0;
      flag_set[`TWS_ST_START] = 1'b1;                   // see (R13)
    end
    if (ctrl_wr | ~en_reg) begin
      state_next      = S_IDLE;
      start_pend_next = 1'b0;
      ovf_pend_next   = 1'b0;
      sda_oe_next     = 1'b0;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_reg      <= S_IDLE;
      start_pend_reg <= 1'b0;
      ovf_pend_reg   <= 1'b0;
      rd_after_reg   <= 1'b0;
      dir_reg        <= 1'b0;
      flag_reg       <= 7'h00;
      rx_full_reg    <= 1'b0;
      rx_buf_reg     <= 8'h00;
      tx_valid_reg   <= 1'b0;
      tx_buf_reg     <= 8'h00;
      sda_oe_reg     <= 1'b0;
      scl_oe_reg     <= 1'b0;
    end else begin
      state_reg      <= state_next;
      start_pend_reg <= start_pend_next;
      ovf_pend_reg   <= ovf_pend_next;
      rd_after_reg   <= rd_after_next;
      dir_reg        <= dir_next;
      // Set wins over a write-one-to-clear in the same cycle
      flag_reg <= (flag_reg & ~(stat_wr ? w_data_reg[6:0] : 7'h00)) |
                  flag_set;
      if (rx_push) begin
        rx_full_reg <= 1'b1;
        rx_buf_reg  <= sh_data;
      end else if (buf_rd) begin
        rx_full_reg <= 1'b0;
      end
      if (buf_wr) begin
        tx_valid_reg <= 1'b1;
        tx_buf_reg   <= w_data_reg[7:0];
      end else if (tx_pop) begin
        tx_valid_reg <= 1'b0;
      end
      sda_oe_reg <= sda_oe_next;
      // Only pull SCL once the master has it low; never make edges.
      // A hold outlasts its service by a cycle so SDA settles first.
      scl_oe_reg <= (start_pend_next | ovf_pend_next |
                     (scl_oe_reg & ovf_pend_reg)) & ~scl_s; // see (R14)
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign scl_o         = 1'b0;
  assign scl_oe        = scl_oe_reg;
  assign sda_o         = 1'b0;
  assign sda_oe        = sda_oe_reg;
endmodule // tws_top
`default_nettype wire

// File: dv/tws_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ---
// Port checks
// ---
module tws_top_monitor (
  // Clock, reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // Bus pins
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_o,
  input wire logic sda_oe
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_scl_only_low: assert property (scl_o == 1'b0)
    else $error("scl driven high");
  a_sda_only_low: assert property (sda_o == 1'b0)
    else $error("sda driven high");
  a_sda_on_low: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("sda moved while scl high");
  // Bench answers a stall within a few cycles
  a_hold_short: assert property ($rose(scl_oe)
    |-> ##[1:20] !scl_oe) else $error("clock hold too long");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("no read answer");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  a_write_busy: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready) else $error("write taken");
  a_b_release: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid) else $error("bvalid stuck");
endmodule // tws_top_monitor
bind tws_top tws_top_monitor tws_top_monitor_i (.*);
`default_nettype wire

// File: dv/tws_bfm.sv
`timescale 1ns/1ps
`default_nettype none
// ---
// Bus master model
// ---
module tws_bfm (
  // Resolved lines
  input  wire logic scl,
  input  wire logic sda,
  // Pull-down enables
  output var logic  scl_oe,
  output var logic  sda_oe
);
  initial begin
    scl_oe = 0;
    sda_oe = 0;
  end
  // Data moves 20 ns after the fall, clear of the sync window
  task automatic bit_cyc(input logic b, output logic s);
    #20 sda_oe = !b;
    #60 scl_oe = 0;
    wait (scl);
    #40 s = sda;
    #40 scl_oe = 1;
  endtask
  task automatic start;
    #20 sda_oe = 0;
    #60 scl_oe = 0;
    wait (scl);
    #80 sda_oe = 1;
    #80 scl_oe = 1;
  endtask
  task automatic stop;
    #20 sda_oe = 1;
    #60 scl_oe = 0;
    wait (scl);
    #80 sda_oe = 0;
    #80;
  endtask
  task automatic xfer(input logic [7:0] d, input logic n9,
    output logic [7:0] q, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cyc(d[i], q[i]);
    bit_cyc(n9, s);
    ack = !s;
  endtask
endmodule // tws_bfm
`default_nettype wire

// File: dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "tws_regs.vh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
// ---
// Bench top
// ---
module testbench;
  logic        aclk = 0, aresetn = 0, tm = 0, ak;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0]  awaddr = 0, araddr = 0, q, x;
  logic [31:0] wdata = 0, d, e;
  logic [6:0]  own;
  logic [1:0]  r;
  int          n_fail = 0, compares = 0, seed = 33093;
  wire         awready, wready, bvalid, arready, rvalid;
  wire         scl_oe, sda_oe, m_scl, m_sda;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire         scl = ~(m_scl | scl_oe);
  wire         sda = ~(m_sda | sda_oe);
  always #4 aclk = ~aclk;
  tws_top tws_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .timer_match(tm), .scl_i(scl), .scl_o(),
    .scl_oe(scl_oe), .sda_i(sda), .sda_o(), .sda_oe(sda_oe));
  tws_bfm tws_bfm_i (.scl(scl), .sda(sda), .scl_oe(m_scl), .sda_oe(m_sda));
  function automatic [7:0] adr(input [6:0] o, input dr);
    adr = {o, dr};
  endfunction
  function automatic [31:0] shl(input [7:0] v);
    // SDA stays low after START, so a zero shifts in
    shl = {24'h0, v[6:0], 1'b0};
  endfunction
  task automatic wr(input [7:0] a, input [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    r = bresp;
    bready <= 0;
  endtask
  task automatic rd(input [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 0;
  endtask
  task automatic ck(input string n, input [7:0] a, input [31:0] m, v);
    rd(a);
    `CHK(n, v, d & m)
  endtask
  task automatic conclude;
    if (n_fail == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #300000;
    n_fail++;
    conclude;
  end
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    own = $random(seed);
    own[0] = 1'b1;
    ck("ctrl", `TWS_CTRL_ADDR, 32'hffffffff, 32'h0);
    rd(8'h14);
    `CHK("rresp", `TWS_RESP_SLVERR, r)
    wr(8'h14, 32'h0);
    `CHK("bresp", `TWS_RESP_SLVERR, r)
    wr(`TWS_CTRL_ADDR, {17'h0, own, 8'h01});
    tws_bfm_i.start;
    tws_bfm_i.xfer(adr(own, 0), 1, q, ak);
    `CHK("addr ack", 1'b1, ak)
    ck("status", `TWS_STAT_ADDR, 32'h0b, 32'h03);
    wr(`TWS_STAT_ADDR, 32'h7f);
    repeat (2) begin
      x = $random(seed);
      tws_bfm_i.xfer(x, 1, q, ak);
      `CHK("data ack", 1'b1, ak)
      ck("rx byte", `TWS_BUF_ADDR, 32'hff, {24'h0, x});
    end
    tws_bfm_i.stop;
    ck("rx done", `TWS_STAT_ADDR, 32'h10, 32'h10);
    wr(`TWS_STAT_ADDR, 32'h7f);
    x = $random(seed);
    wr(`TWS_BUF_ADDR, {24'h0, x});
    tws_bfm_i.start;
    tws_bfm_i.xfer(adr(own, 1), 1, q, ak);
    `CHK("read ack", 1'b1, ak)
    tws_bfm_i.xfer(8'hff, 1, q, ak);
    `CHK("tx byte", x, q)
    tws_bfm_i.stop;
    ck("tx done", `TWS_STAT_ADDR, 32'h28, 32'h28);
    tws_bfm_i.start;
    tws_bfm_i.xfer(adr(own ^ 7'h02, 0), 1, q, ak);
    `CHK("foreign ack", 1'b0, ak)
    tws_bfm_i.stop;
    wr(`TWS_STAT_ADDR, 32'h7f);
    tws_bfm_i.start;
    tws_bfm_i.xfer(adr(`TWS_GCALL_ADDR, 0), 1, q, ak);
    `CHK("gcall ack", 1'b1, ak)
    ck("gcall", `TWS_STAT_ADDR, 32'h04, 32'h04);
    tws_bfm_i.start;
    tws_bfm_i.xfer(adr(own, 0), 1, q, ak);
    `CHK("restart ack", 1'b1, ak)
    tws_bfm_i.start;
    tws_bfm_i.xfer(adr(own, 1), 1, q, ak);
    `CHK("empty ack", 1'b0, ak)
    ck("abort", `TWS_STAT_ADDR, 32'h40, 32'h40);
    tws_bfm_i.stop;
    wr(`TWS_CTRL_ADDR, {17'h0, own, 8'h09});
    x = $random(seed);
    tws_bfm_i.start;
    fork
      tws_bfm_i.xfer(adr(own, 1), 1, q, ak);
      begin
        @(posedge scl_oe);
        wr(`TWS_BUF_ADDR, {24'h0, x});
      end
    join
    `CHK("stall ack", 1'b1, ak)
    tws_bfm_i.xfer(8'hff, 1, q, ak);
    `CHK("stall byte", x, q)
    tws_bfm_i.stop;
    wr(`TWS_CTRL_ADDR, {17'h0, own, 8'h05});
    tws_bfm_i.start;
    rd(`TWS_SHIFT_ADDR);
    e = shl(d[7:0]);
    wr(`TWS_STROBE_ADDR, 32'h1);
    ck("soft tick", `TWS_SHIFT_ADDR, 32'hff, e);
    wr(`TWS_CTRL_ADDR, {17'h0, own, 8'h03});
    tws_bfm_i.start;
    rd(`TWS_SHIFT_ADDR);
    e = shl(d[7:0]);
    @(posedge aclk);
    tm <= 1;
    @(posedge aclk);
    tm <= 0;
    ck("timer tick", `TWS_SHIFT_ADDR, 32'hff, e);
    conclude;
  end
endmodule // testbench
`default_nettype wire
